// file: design/exu_params.svh
// constants for the execution datapath: flag bit positions and cycle counts
// assumes the includer also imports exu_pkg for the operation codes
`ifndef EXU_PARAMS_SVH
`define EXU_PARAMS_SVH

// status flag bit positions inside the flag byte
`define EXU_FLG_C 0
`define EXU_FLG_Z 1
`define EXU_FLG_N 2
`define EXU_FLG_V 3
`define EXU_FLG_S 4
`define EXU_FLG_H 5

// flag byte after reset
`define EXU_FLG_RST 8'h00

// cycle counts per instruction class
`define EXU_CYC_ONE   2'h1
`define EXU_CYC_TWO   2'h2
`define EXU_CYC_THREE 2'h3

// all-ones byte used to invert the clear mask
`define EXU_MASK_ALL 8'hFF

`endif

// file: design/exu_pkg.sv
// types shared by the execution datapath files
// assumes nothing of its surroundings
package exu_pkg;

    typedef enum logic [4:0] {
        OP_SUM_REGISTERS       = 5'h00,
        OP_SUM_WITH_CARRY      = 5'h01,
        OP_WORD_IMM_SUM        = 5'h02,
        OP_DIFF_REGISTERS      = 5'h03,
        OP_DIFF_IMMEDIATE      = 5'h04,
        OP_DIFF_WITH_BORROW    = 5'h05,
        OP_DIFF_IMM_BORROW     = 5'h06,
        OP_WORD_IMM_DIFF       = 5'h07,
        OP_LOGICAL_CONJ        = 5'h08,
        OP_CONJ_IMMEDIATE      = 5'h09,
        OP_LOGICAL_DISJ        = 5'h0A,
        OP_DISJ_IMMEDIATE      = 5'h0B,
        OP_EXCLUSIVE_DISJ      = 5'h0C,
        OP_SET_BITS_MASK       = 5'h0D,
        OP_CLEAR_BITS_MASK     = 5'h0E,
        OP_ZERO_SIGN_TEST      = 5'h0F,
        OP_PRODUCT_UNSIGNED    = 5'h10,
        OP_PRODUCT_SIGNED      = 5'h11,
        OP_PRODUCT_MIXED       = 5'h12,
        OP_FRACTION_UNSIGNED   = 5'h13,
        OP_FRACTION_SIGNED     = 5'h14,
        OP_FRACTION_MIXED      = 5'h15,
        OP_JUMP_VIA_POINTER    = 5'h16,
        OP_CALL_VIA_POINTER    = 5'h17,
        OP_COMPARE_SKIP_EQUAL  = 5'h18,
        OP_COMPARE             = 5'h19,
        OP_COMPARE_WITH_BORROW = 5'h1A,
        OP_COMPARE_IMMEDIATE   = 5'h1B
    } exu_op_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_WAIT = 2'h2
    } exu_state_type;

endpackage

// file: design/exu_mul.sv
// 8x8 multiplier with per-operand signedness and fractional shift
// assumes the caller registers the outputs
`timescale 1ns/1ps

module exu_mul (
    // operands
    input  wire logic [7:0]  mul_a,
    input  wire logic [7:0]  mul_b,
    // mode
    input  wire logic        sign_a,
    input  wire logic        sign_b,
    input  wire logic        frac,
    // result
    output logic      [15:0] prod,
    output logic             prod_carry
);
    wire logic signed [8:0]  ext_a = {sign_a & mul_a[7], mul_a};
    wire logic signed [8:0]  ext_b = {sign_b & mul_b[7], mul_b};
    wire logic signed [17:0] raw   = ext_a * ext_b;

    // carry is taken from the unshifted product's top bit
    assign prod_carry = raw[15];
    assign prod       = frac ? {raw[14:0], 1'b0} : raw[15:0];

endmodule // exu_mul

// file: design/exu_core.sv
// execution datapath: arithmetic, logic, multiply, compare, pointer jumps
// assumes one operation is offered at a time while op_busy is low
//
// Contract
// (RQ1) add two registers, optionally with carry; five flags; one cycle
// (RQ2) add immediate to register pair in two cycles, Z C N V S
// (RQ3) subtract register or immediate; write target; five flags; one cycle
// (RQ4) subtract forms with borrow also subtract carry; one cycle
// (RQ5) subtract immediate from register pair in two cycles, Z C N V S
// (RQ6) and, or, xor forms: one cycle, only Z N V change
// (RQ7) set mask ors immediate; clear mask ands inverted mask; Z N V
// (RQ8) zero/sign test ands target with itself; Z N V; one cycle
// (RQ9) multiplies unsigned, signed, mixed into product pair; two cycles; Z C
// (RQ10) fractional multiplies shift product left one; two cycles; Z C
// (RQ11) pointer jump loads program counter; two cycles; flags unchanged
// (RQ12) pointer call pushes return address, loads counter; three cycles
// (RQ13) compare-skip skips when equal; 1/2/3 cycles; no flags
// (RQ14) compares subtract without writing; one cycle; five flags
// (RQ15) flags an instruction does not list keep their value
// (RQ16) S flag equals N xor V whenever it is updated
`timescale 1ns/1ps
`include "exu_params.svh"

module exu_core (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    // operation request
    input  wire logic                op_valid,
    input  wire exu_pkg::exu_op_type op_code,
    input  wire logic [7:0]          rd_val,
    input  wire logic [7:0]          rr_val,
    input  wire logic [7:0]          imm_val,
    input  wire logic [15:0]         pair_val,
    input  wire logic [15:0]         ptr_val,
    input  wire logic [15:0]         pc_val,
    input  wire logic                next_two_word,
    // completion
    output logic                     op_busy,
    output logic                     op_done,
    // register writes
    output logic                     rd_wr,
    output logic [7:0]               rd_res,
    output logic                     pair_wr,
    output logic [15:0]              pair_res,
    output logic                     prod_wr,
    output logic [15:0]              prod_res,
    // program flow
    output logic                     pc_load,
    output logic [15:0]              pc_next,
    output logic                     ret_push,
    output logic [15:0]              ret_addr,
    // status flags
    output logic [7:0]               flags
);
    import exu_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic          rst_m_r;
    logic          rst_s_r;
    wire logic     rst_sync_b = rst_s_r;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_m_r <= 1'b0;
            rst_s_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_s_r <= rst_m_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode
    exu_state_type state_r;
    logic [1:0]    remain_r;
    logic [7:0]    flags_r;

    wire logic take = op_valid && (state_r == ST_IDLE);
    wire logic c_in = flags_r[`EXU_FLG_C];

    wire logic is_add   = op_code == OP_SUM_REGISTERS
                       || op_code == OP_SUM_WITH_CARRY;
    wire logic is_cmp   = op_code == OP_COMPARE
                       || op_code == OP_COMPARE_WITH_BORROW
                       || op_code == OP_COMPARE_IMMEDIATE;
    wire logic is_sub   = is_cmp || op_code == OP_DIFF_REGISTERS
                       || op_code == OP_DIFF_IMMEDIATE
                       || op_code == OP_DIFF_WITH_BORROW
                       || op_code == OP_DIFF_IMM_BORROW;
    wire logic use_cin  = op_code == OP_SUM_WITH_CARRY
                       || op_code == OP_DIFF_WITH_BORROW
                       || op_code == OP_DIFF_IMM_BORROW
                       || op_code == OP_COMPARE_WITH_BORROW;
    wire logic use_imm  = op_code == OP_DIFF_IMMEDIATE
                       || op_code == OP_DIFF_IMM_BORROW
                       || op_code == OP_COMPARE_IMMEDIATE
                       || op_code == OP_CONJ_IMMEDIATE
                       || op_code == OP_DISJ_IMMEDIATE
                       || op_code == OP_SET_BITS_MASK
                       || op_code == OP_CLEAR_BITS_MASK;
    wire logic is_and   = op_code == OP_LOGICAL_CONJ
                       || op_code == OP_CONJ_IMMEDIATE;
    wire logic is_or    = op_code == OP_LOGICAL_DISJ
                       || op_code == OP_DISJ_IMMEDIATE
                       || op_code == OP_SET_BITS_MASK;
    wire logic is_logic = is_and || is_or
                       || op_code == OP_EXCLUSIVE_DISJ
                       || op_code == OP_CLEAR_BITS_MASK
                       || op_code == OP_ZERO_SIGN_TEST;
    wire logic is_word  = op_code == OP_WORD_IMM_SUM
                       || op_code == OP_WORD_IMM_DIFF;
    wire logic is_mul   = op_code >= OP_PRODUCT_UNSIGNED
                       && op_code <= OP_FRACTION_MIXED;
    wire logic is_jmp   = op_code == OP_JUMP_VIA_POINTER;
    wire logic is_call  = op_code == OP_CALL_VIA_POINTER;
    wire logic is_skip  = op_code == OP_COMPARE_SKIP_EQUAL;

    ////////////////////////////////////////////////////////////////////////
    // byte arithmetic
    wire logic [7:0] opnd_b = use_imm ? imm_val : rr_val;
    wire logic       cin    = use_cin & c_in;                       // RQ4
    wire logic [8:0] sum9   = {1'b0, rd_val} + {1'b0, opnd_b}
                            + {8'h00, cin};                         // RQ1
    wire logic [8:0] dif9   = {1'b0, rd_val} - {1'b0, opnd_b}
                            - {8'h00, cin};                         // RQ3
    wire logic [7:0] ar     = is_sub ? dif9[7:0] : sum9[7:0];
    wire logic       ar_c   = is_sub ? dif9[8] : sum9[8];
    wire logic a3 = rd_val[3];
    wire logic b3 = opnd_b[3];
    wire logic r3 = ar[3];
    wire logic a7 = rd_val[7];
    wire logic b7 = opnd_b[7];
    wire logic r7 = ar[7];
    wire logic ar_h = is_sub ? ((~a3 & b3) | (b3 & r3) | (r3 & ~a3))
                             : ((a3 & b3) | (b3 & ~r3) | (~r3 & a3));
    wire logic ar_v = is_sub ? ((a7 & ~b7 & ~r7) | (~a7 & b7 & r7))
                             : ((a7 & b7 & ~r7) | (~a7 & ~b7 & r7));

    ////////////////////////////////////////////////////////////////////////
    // logic unit
    wire logic [7:0] lr =
        is_and ? (rd_val & opnd_b) :                                // RQ6
        is_or  ? (rd_val | opnd_b) :                                // RQ7
        (op_code == OP_EXCLUSIVE_DISJ) ? (rd_val ^ opnd_b) :
        (op_code == OP_CLEAR_BITS_MASK)
               ? (rd_val & (`EXU_MASK_ALL - opnd_b)) :              // RQ7
        (rd_val & rd_val);                                          // RQ8

    ////////////////////////////////////////////////////////////////////////
    // word arithmetic
    wire logic        w_sub = op_code == OP_WORD_IMM_DIFF;
    wire logic [15:0] wr    = w_sub ? pair_val - {8'h00, imm_val}   // RQ5
                                    : pair_val + {8'h00, imm_val};  // RQ2
    wire logic        w_v   = w_sub ? (pair_val[15] & ~wr[15])
                                    : (~pair_val[15] & wr[15]);
    wire logic        w_c   = w_sub ? (wr[15] & ~pair_val[15])
                                    : (~wr[15] & pair_val[15]);

    ////////////////////////////////////////////////////////////////////////
    // multiplier
    logic [15:0] mp;
    logic        mp_c;
    wire logic   m_sa = op_code == OP_PRODUCT_SIGNED
                     || op_code == OP_PRODUCT_MIXED
                     || op_code == OP_FRACTION_SIGNED
                     || op_code == OP_FRACTION_MIXED;
    wire logic   m_sb = op_code == OP_PRODUCT_SIGNED
                     || op_code == OP_FRACTION_SIGNED;
    wire logic   m_fr = op_code >= OP_FRACTION_UNSIGNED;

    exu_mul u_mul (
        .mul_a      (rd_val),
        .mul_b      (rr_val),
        .sign_a     (m_sa),
        .sign_b     (m_sb),
        .frac       (m_fr),
        .prod       (mp),
        .prod_carry (mp_c)
    );

    ////////////////////////////////////////////////////////////////////////
    // flag update and cycle count
    wire logic       equal  = rd_val == rr_val;
    wire logic [1:0] cycles =
        (is_word || is_mul || is_jmp) ? `EXU_CYC_TWO :     // RQ2 RQ9 RQ11
        is_call ? `EXU_CYC_THREE :                         // RQ12
        (is_skip && equal) ? (next_two_word ? `EXU_CYC_THREE
                                            : `EXU_CYC_TWO) :     // RQ13
        `EXU_CYC_ONE;

    logic [7:0] flags_nxt;
    always_comb begin
        flags_nxt = flags_r;                                        // RQ15
        if (is_add || is_sub) begin
            flags_nxt[`EXU_FLG_Z] = ar == 8'h00;                    // RQ14
            flags_nxt[`EXU_FLG_C] = ar_c;
            flags_nxt[`EXU_FLG_N] = ar[7];
            flags_nxt[`EXU_FLG_V] = ar_v;
            flags_nxt[`EXU_FLG_H] = ar_h;
        end else if (is_logic) begin
            flags_nxt[`EXU_FLG_Z] = lr == 8'h00;                    // RQ6
            flags_nxt[`EXU_FLG_N] = lr[7];
            flags_nxt[`EXU_FLG_V] = 1'b0;
        end else if (is_word) begin
            flags_nxt[`EXU_FLG_Z] = wr == 16'h0000;
            flags_nxt[`EXU_FLG_C] = w_c;
            flags_nxt[`EXU_FLG_N] = wr[15];
            flags_nxt[`EXU_FLG_V] = w_v;
            flags_nxt[`EXU_FLG_S] = wr[15] ^ w_v;                   // RQ16
        end else if (is_mul) begin
            flags_nxt[`EXU_FLG_Z] = mp == 16'h0000;                 // RQ10
            flags_nxt[`EXU_FLG_C] = mp_c;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencing: results latch on acceptance, op_done marks completion
    wire logic last = (state_r == ST_WAIT) && (remain_r == `EXU_CYC_ONE);

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state_r  <= ST_IDLE;
            remain_r <= 2'h0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (take && cycles != `EXU_CYC_ONE) begin
                        state_r  <= ST_WAIT;
                        remain_r <= cycles - `EXU_CYC_ONE;
                    end
                end
                ST_WAIT: begin
                    remain_r <= remain_r - `EXU_CYC_ONE;
                    if (last) begin
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            op_busy  <= 1'b0;
            op_done  <= 1'b0;
            rd_wr    <= 1'b0;
            pair_wr  <= 1'b0;
            prod_wr  <= 1'b0;
            pc_load  <= 1'b0;
            ret_push <= 1'b0;
            rd_res   <= 8'h00;
            pair_res <= 16'h0000;
            prod_res <= 16'h0000;
            pc_next  <= 16'h0000;
            ret_addr <= 16'h0000;
            flags_r  <= `EXU_FLG_RST;
        end else begin
            op_busy <= take ? (cycles != `EXU_CYC_ONE) : (op_busy && !last);
            op_done <= take ? (cycles == `EXU_CYC_ONE) : last;
            if (take) begin
                rd_wr    <= is_add || (is_sub && !is_cmp) || is_logic; // RQ14
                pair_wr  <= is_word;
                prod_wr  <= is_mul;                                 // RQ9
                pc_load  <= is_jmp || is_call || is_skip;
                ret_push <= is_call;                                // RQ12
                rd_res   <= is_logic ? lr : ar;
                pair_res <= wr;
                prod_res <= mp;
                // skip distance counts the skipped instruction's words
                pc_next  <= is_skip ? pc_val + {14'h0000, cycles}   // RQ13
                                    : ptr_val;                      // RQ11
                ret_addr <= pc_val + 16'h0001;
                flags_r  <= flags_nxt;
            end
        end
    end

    assign flags = flags_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_one_cycle_add: assert property (@(posedge clk_sys)         // RQ1
        disable iff (!rst_sync_b)
        take && is_add |=> op_done && rd_wr && rd_res == $past(sum9[7:0]))
        else $error("add did not finish in one cycle");
    a_word_two_cyc: assert property (@(posedge clk_sys)          // RQ2
        disable iff (!rst_sync_b)
        take && is_word |=> !op_done ##1 op_done && pair_wr)
        else $error("word op did not take two cycles");
    a_borrow_used: assert property (@(posedge clk_sys)           // RQ4
        disable iff (!rst_sync_b)
        take && op_code == OP_DIFF_WITH_BORROW |=>
            rd_res == $past(rd_val) - $past(rr_val) - {7'h00, $past(c_in)})
        else $error("borrow not subtracted");
    a_logic_keep_c: assert property (@(posedge clk_sys)          // RQ6
        disable iff (!rst_sync_b)
        take && is_logic |=> flags_r[`EXU_FLG_C] == $past(c_in)
            && !flags_r[`EXU_FLG_V])
        else $error("logic op disturbed carry");
    a_mul_two_cyc: assert property (@(posedge clk_sys)           // RQ9
        disable iff (!rst_sync_b)
        take && is_mul |=> op_busy ##1 op_done && prod_wr)
        else $error("multiply timing wrong");
    a_call_three: assert property (@(posedge clk_sys)            // RQ12
        disable iff (!rst_sync_b)
        take && is_call |=> (ret_push && !op_done) [*2] ##1 op_done)
        else $error("call did not take three cycles");
    a_jump_flags: assert property (@(posedge clk_sys)            // RQ11
        disable iff (!rst_sync_b)
        take && is_jmp |=> pc_next == $past(ptr_val) && $stable(flags_r))
        else $error("jump changed flags or target");
    a_skip_noflag: assert property (@(posedge clk_sys)           // RQ13
        disable iff (!rst_sync_b)
        take && is_skip && !equal |=> op_done
            && pc_next == $past(pc_val) + 16'h0001 && $stable(flags_r))
        else $error("compare-skip miss wrong");
    a_cmp_no_write: assert property (@(posedge clk_sys)          // RQ14
        disable iff (!rst_sync_b)
        take && is_cmp |=> !rd_wr && op_done)
        else $error("compare wrote a register");
    a_sign_flag: assert property (@(posedge clk_sys)             // RQ16
        disable iff (!rst_sync_b)
        op_done && pair_wr |-> flags_r[`EXU_FLG_S]
            == (flags_r[`EXU_FLG_N] ^ flags_r[`EXU_FLG_V]))
        else $error("sign flag not n xor v");

    c_add_done:  cover property (@(posedge clk_sys) take && is_add);
    c_mul_done:  cover property (@(posedge clk_sys) take && is_mul);
    c_call_done: cover property (@(posedge clk_sys) take && is_call);
    c_skip_far:  cover property (@(posedge clk_sys)
        take && is_skip && equal && next_two_word);

endmodule // exu_core

// file: tb/exu_core_tb_top.sv
// self-checking bench for the execution datapath, one task per scenario
// assumes exu_pkg is compiled first and exu_params.svh is on the include path
`timescale 1ns/1ps
`include "exu_params.svh"

`define TB_CHK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("wrong value at %0t: got %0h expected %0h", \
                 $time, (got), (exp)); \
    end \
end

module exu_core_tb_top;
    import exu_pkg::*;

    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        op_valid = 1'b0;
    exu_op_type  op_code = OP_SUM_REGISTERS;
    logic [7:0]  rd_val = 8'h00;
    logic [7:0]  rr_val = 8'h00;
    logic [7:0]  imm_val = 8'h00;
    logic [15:0] pair_val = 16'h0000;
    logic [15:0] ptr_val = 16'h0000;
    logic [15:0] pc_val = 16'h0000;
    logic        next_two_word = 1'b0;
    logic        op_busy, op_done, rd_wr, pair_wr, prod_wr;
    logic        pc_load, ret_push;
    logic [7:0]  rd_res, flags;
    logic [15:0] pair_res, prod_res, pc_next, ret_addr;
    logic [7:0]  ef = `EXU_FLG_RST;
    logic        bsy;
    int          cyc;
    int          n_mismatch = 0;
    int          tests_run = 0;

    always #50 clk_sys = ~clk_sys;

    exu_core i_exu_core (
        .clk_sys(clk_sys), .rst_b(rst_b), .op_valid(op_valid),
        .op_code(op_code), .rd_val(rd_val), .rr_val(rr_val),
        .imm_val(imm_val), .pair_val(pair_val), .ptr_val(ptr_val),
        .pc_val(pc_val), .next_two_word(next_two_word),
        .op_busy(op_busy), .op_done(op_done), .rd_wr(rd_wr),
        .rd_res(rd_res), .pair_wr(pair_wr), .pair_res(pair_res),
        .prod_wr(prod_wr), .prod_res(prod_res), .pc_load(pc_load),
        .pc_next(pc_next), .ret_push(ret_push), .ret_addr(ret_addr),
        .flags(flags)
    );

    ////////////////////////////////////////////////////////////////////////
    // expected flags: sub reuses the add formulas on inverted a and result
    function automatic logic [7:0] ar8(input logic [7:0] a, b,
                                       input logic s, ci);
        logic [7:0] r, x, y;
        r = s ? a - b - 8'(ci) : a + b + 8'(ci);
        x = s ? ~a : a;
        y = s ? ~r : r;
        ef[`EXU_FLG_C] = x[7] & b[7] | b[7] & ~y[7] | ~y[7] & x[7];
        ef[`EXU_FLG_H] = x[3] & b[3] | b[3] & ~y[3] | ~y[3] & x[3];
        ef[`EXU_FLG_V] = x[7] & b[7] & ~y[7] | ~x[7] & ~b[7] & y[7];
        ef[`EXU_FLG_N] = r[7];
        ef[`EXU_FLG_Z] = (r == 8'h00);
        return r;
    endfunction

    function automatic logic [15:0] ar16(input logic [15:0] a, b,
                                         input logic s);
        logic [15:0] r, x, y;
        r = s ? a - b : a + b;
        x = s ? ~a : a;
        y = s ? ~r : r;
        ef[`EXU_FLG_C] = x[15] & b[15] | b[15] & ~y[15] | ~y[15] & x[15];
        ef[`EXU_FLG_V] = x[15] & b[15] & ~y[15] | ~x[15] & ~b[15] & y[15];
        ef[`EXU_FLG_N] = r[15];
        ef[`EXU_FLG_Z] = (r == 16'h0000);
        ef[`EXU_FLG_S] = r[15] ^ ef[`EXU_FLG_V];
        return r;
    endfunction

    function automatic logic [7:0] lg(input logic [7:0] r);
        ef[`EXU_FLG_Z] = (r == 8'h00);
        ef[`EXU_FLG_N] = r[7];
        ef[`EXU_FLG_V] = 1'b0;
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // one request; lowered after the take edge so it is never taken twice
    task automatic run(input exu_op_type op, input logic [7:0] a, r, k);
        @(negedge clk_sys);
        op_code  = op;
        rd_val   = a;
        rr_val   = r;
        imm_val  = k;
        op_valid = 1'b1;
        @(negedge clk_sys);
        op_valid = 1'b0;
        bsy      = op_busy;
        cyc      = 1;
        while (op_done !== 1'b1 && cyc < 8) begin
            @(negedge clk_sys);
            cyc++;
        end
    endtask

    task automatic chk(input logic [15:0] got, exp, input logic wr, we,
                       input int n);
        `TB_CHK(got, exp)
        `TB_CHK(wr, we)
        `TB_CHK(flags, ef)
        `TB_CHK(cyc, n)
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_word;
        logic [15:0] pv [4] = '{16'hFFFF, 16'h7FFF, 16'h0000, 16'h8000};
        logic [15:0] e;
        foreach (pv[i]) begin
            pair_val = pv[i];
            e = ar16(pv[i], 16'h0001, i >= 2);
            run(i >= 2 ? OP_WORD_IMM_DIFF : OP_WORD_IMM_SUM,
                8'h00, 8'hFF, 8'h01);
            chk(pair_res, e, pair_wr, 1'b1, 2);
        end
    endtask

    task automatic t_add;
        logic [7:0] e;
        e = ar8(8'h7F, 8'h01, 1'b0, 1'b0);
        run(OP_SUM_REGISTERS, 8'h7F, 8'h01, 8'h00);
        chk({8'h00, rd_res}, {8'h00, e}, rd_wr, 1'b1, 1);
        e = ar8(8'hFF, 8'h01, 1'b0, 1'b0);
        run(OP_SUM_REGISTERS, 8'hFF, 8'h01, 8'h00);
        chk({8'h00, rd_res}, {8'h00, e}, rd_wr, 1'b1, 1);
        e = ar8(8'h18, 8'h27, 1'b0, ef[`EXU_FLG_C]);
        run(OP_SUM_WITH_CARRY, 8'h18, 8'h27, 8'h00);
        chk({8'h00, rd_res}, {8'h00, e}, rd_wr, 1'b1, 1);
    endtask

    task automatic t_sub;
        exu_op_type ops [9] = '{OP_DIFF_REGISTERS, OP_DIFF_IMMEDIATE,
            OP_DIFF_REGISTERS, OP_DIFF_WITH_BORROW, OP_DIFF_REGISTERS,
            OP_DIFF_IMM_BORROW, OP_COMPARE, OP_COMPARE_WITH_BORROW,
            OP_COMPARE_IMMEDIATE};
        logic [7:0] av [9] = '{8'h00, 8'h05, 8'h00, 8'h10, 8'h00, 8'h23,
                               8'h00, 8'h10, 8'h80};
        logic [7:0] bv [9] = '{8'h01, 8'h05, 8'h01, 8'h0F, 8'h01, 8'h05,
                               8'h01, 8'h0F, 8'h01};
        logic [7:0] e;
        logic       im, bw, cp;
        foreach (ops[i]) begin
            im = ops[i] inside {OP_DIFF_IMMEDIATE, OP_DIFF_IMM_BORROW,
                                OP_COMPARE_IMMEDIATE};
            bw = ops[i] inside {OP_DIFF_WITH_BORROW, OP_DIFF_IMM_BORROW,
                                OP_COMPARE_WITH_BORROW};
            cp = ops[i] inside {OP_COMPARE, OP_COMPARE_WITH_BORROW,
                                OP_COMPARE_IMMEDIATE};
            e = ar8(av[i], bv[i], 1'b1, bw & ef[`EXU_FLG_C]);
            run(ops[i], av[i], im ? ~bv[i] : bv[i], im ? bv[i] : ~bv[i]);
            chk({8'h00, rd_res}, {8'h00, e}, rd_wr, !cp, 1);
        end
    endtask

    task automatic t_logic;
        exu_op_type ops [8] = '{OP_LOGICAL_CONJ, OP_CONJ_IMMEDIATE,
            OP_LOGICAL_DISJ, OP_DISJ_IMMEDIATE, OP_EXCLUSIVE_DISJ,
            OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK, OP_ZERO_SIGN_TEST};
        logic [7:0] a, b, e;
        logic       im;
        // carry and half carry set first, so a stray clear shows
        e = ar8(8'h00, 8'h01, 1'b1, 1'b0);
        run(OP_DIFF_REGISTERS, 8'h00, 8'h01, 8'h00);
        b = 8'h3C;
        for (int j = 0; j < 2; j++) begin
            a = j ? 8'h00 : 8'hA5;
            foreach (ops[i]) begin
                im = ops[i] inside {OP_CONJ_IMMEDIATE, OP_DISJ_IMMEDIATE,
                                    OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK};
                case (ops[i])
                    OP_LOGICAL_CONJ, OP_CONJ_IMMEDIATE: e = lg(a & b);
                    OP_EXCLUSIVE_DISJ: e = lg(a ^ b);
                    OP_CLEAR_BITS_MASK: e = lg(a & (`EXU_MASK_ALL - b));
                    OP_ZERO_SIGN_TEST: e = lg(a & a);
                    default: e = lg(a | b);
                endcase
                run(ops[i], a, im ? ~b : b, im ? b : ~b);
                chk(16'(rd_res), 16'(e), rd_wr, 1'b1, 1);
            end
        end
    endtask

    task automatic t_mul;
        exu_op_type ops [6] = '{OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED,
            OP_PRODUCT_MIXED, OP_FRACTION_UNSIGNED, OP_FRACTION_SIGNED,
            OP_FRACTION_MIXED};
        logic [7:0]         av [3] = '{8'h80, 8'h40, 8'h00};
        logic [7:0]         bv [3] = '{8'hFF, 8'hC0, 8'h37};
        logic signed [17:0] pp;
        logic [15:0]        e;
        logic               sa, sb;
        foreach (ops[i]) begin
            sa = !(ops[i] inside {OP_PRODUCT_UNSIGNED, OP_FRACTION_UNSIGNED});
            sb = ops[i] inside {OP_PRODUCT_SIGNED, OP_FRACTION_SIGNED};
            foreach (av[j]) begin
                pp = $signed({sa & av[j][7], av[j]})
                   * $signed({sb & bv[j][7], bv[j]});
                e = (i >= 3) ? {pp[14:0], 1'b0} : pp[15:0];
                ef[`EXU_FLG_C] = pp[15];
                ef[`EXU_FLG_Z] = (e == 16'h0000);
                run(ops[i], av[j], bv[j], ~bv[j]);
                chk(prod_res, e, prod_wr, 1'b1, 2);
                `TB_CHK(bsy, 1'b1)
            end
        end
    endtask

    task automatic t_flow;
        logic [7:0] bv [3] = '{8'h22, 8'h33, 8'h33};
        ptr_val = 16'h1234;
        pc_val  = 16'h0100;
        run(OP_JUMP_VIA_POINTER, 8'h00, 8'h00, 8'h00);
        chk(pc_next, 16'h1234, pc_load, 1'b1, 2);
        run(OP_CALL_VIA_POINTER, 8'h00, 8'h00, 8'h00);
        chk(pc_next, 16'h1234, pc_load, 1'b1, 3);
        `TB_CHK(ret_push, 1'b1)
        `TB_CHK(ret_addr, 16'h0101)
        // the immediate equals rd, so comparing against it would skip
        foreach (bv[i]) begin
            next_two_word = (i == 2);
            run(OP_COMPARE_SKIP_EQUAL, 8'h33, bv[i], 8'h33);
            chk(pc_next, pc_val + 16'(i+1), pc_load, 1'b1, i+1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // about 60 operations of at most 4 cycles; 1000 cycles is ample
    initial begin
        #100_000;
        n_mismatch++;
        wrap_up();
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        `TB_CHK(flags, `EXU_FLG_RST)
        t_word();
        t_add();
        t_sub();
        t_logic();
        t_mul();
        t_flow();
        wrap_up();
    end
endmodule // exu_core_tb_top
